// ### fcsl_regs.svh
// Offsets, field positions, reset values and timing figures (ns, us, clock in kHz) of the flash sequencer
`ifndef FCSL_REGS_SVH
`define FCSL_REGS_SVH

// Register byte offsets
`define FCSL_OFF_CMD     8'h00
`define FCSL_OFF_ADDR    8'h04
`define FCSL_OFF_WDATA   8'h08
`define FCSL_OFF_STATUS  8'h0c
`define FCSL_OFF_RDATA   8'h10

// Status word field positions
`define FCSL_ST_BUSY     0
`define FCSL_ST_DONE     1
`define FCSL_ST_FAIL     2
`define FCSL_ST_BYPASS   3
`define FCSL_ST_SUSP     4
`define FCSL_ST_WIN      5
`define FCSL_ST_REFUSED  6
`define FCSL_ST_SBYTE    16

// Status byte bit positions
`define FCSL_SB_POLL     7
`define FCSL_SB_TOGGLE   6
`define FCSL_SB_FAIL     5
`define FCSL_SB_TIMER    3
`define FCSL_SB_ALT      2

// Defined status bits per operation
`define FCSL_MASK_PROG   8'he0
`define FCSL_MASK_ERASE  8'hec

// Command addresses and data
`define FCSL_CA_555      11'h555
`define FCSL_CA_2AA      11'h2aa
`define FCSL_CD_AA       8'haa
`define FCSL_CD_55       8'h55
`define FCSL_CD_F0       8'hf0
`define FCSL_CD_90       8'h90
`define FCSL_CD_A0       8'ha0
`define FCSL_CD_20       8'h20
`define FCSL_CD_00       8'h00
`define FCSL_CD_80       8'h80
`define FCSL_CD_10       8'h10
`define FCSL_CD_30       8'h30
`define FCSL_CD_B0       8'hb0

// Reset values
`define FCSL_RST_ADDR    17'h00000
`define FCSL_RST_WDATA   8'hff

// Timing
`define FCSL_CLK_KHZ     40000
`define FCSL_T_WP_NS     50
`define FCSL_T_RD_NS     100
`define FCSL_T_BLKWIN_US 50
`define FCSL_T_SUSP_US   15

`endif

// ### fcsl_pkg.sv
// Types of the flash sequencer: states, operations and the state record
package fcsl_pkg;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    FCSL_IDLE   = 8'h01,
    FCSL_WSET   = 8'h02,
    FCSL_WPULSE = 8'h04,
    FCSL_WHOLD  = 8'h08,
    FCSL_WDONE  = 8'h10,
    FCSL_RPULSE = 8'h20,
    FCSL_REVAL  = 8'h40,
    FCSL_WAIT   = 8'h80
  } fcsl_state_t;

  // Operation codes written to the command register
  typedef enum logic [3:0] {
    FCSL_OP_NONE      = 4'h0,
    FCSL_OP_RESET     = 4'h1,
    FCSL_OP_AUTOSEL   = 4'h2,
    FCSL_OP_PROG      = 4'h3,
    FCSL_OP_BYP_ENTER = 4'h4,
    FCSL_OP_BYP_PROG  = 4'h5,
    FCSL_OP_BYP_EXIT  = 4'h6,
    FCSL_OP_CHIP_ERA  = 4'h7,
    FCSL_OP_BLK_ERA   = 4'h8,
    FCSL_OP_BLK_ADD   = 4'h9,
    FCSL_OP_SUSPEND   = 4'ha,
    FCSL_OP_RESUME    = 4'hb,
    FCSL_OP_READ      = 4'hc,
    FCSL_OP_POLL      = 4'hd,
    FCSL_OP_RESET_UNL = 4'he
  } fcsl_op_t;

  // Whole state of the top module
  typedef struct packed {
    fcsl_state_t st;
    fcsl_op_t    op;
    logic [2:0]  step;
    logic [11:0] cnt;
    logic [11:0] win;
    logic [16:0] addr;
    logic [7:0]  wdat;
    logic [7:0]  rdat;
    logic [7:0]  prev;
    logic [7:0]  sbyte;
    logic        havep;
    logic        chk;
    logic        done;
    logic        fail;
    logic        bypass;
    logic        susp;
    logic        refused;
    logic        aw;
    logic        amap;
    logic [7:0]  aoff;
    logic [31:0] hrdata;
    logic        rdy;
    logic [16:0] fa;
    logic [7:0]  fdo;
    logic        foe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } fcsl_regs_t;

endpackage

// ### fcsl_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module fcsl_sync #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;   // Only read by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stab; // Agreed value
  } fcsl_sync_t;

  fcsl_sync_t q;
  fcsl_sync_t d;

  if (W < 1) begin : g_chk
    $error("fcsl_sync width must be at least one");
  end

  // Shift chain, stable value moves only on agreement
  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.stab = q.s3;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.stab;
endmodule

// ### fcsl_host.sv
// Host-side controller that issues flash command sequences and polls the status byte
// Rules of the flash datasheet
// RL1: Multi-write commands open with AA@555, 55@2AA
// RL2: Only address bits 0-10 carry command addresses
// RL3: Reset: F0 alone, or after unlock
// RL4: Identify: unlock then 90 at 555
// RL5: Program: unlock, A0@555, then location and value
// RL6: Bypass: 20@555; A0 then data; exit 90,00
// RL7: Chip erase six writes, then poll status
// RL8: Block erase sixth write 30; add before timeout
// RL9: B0 anywhere suspends block erase
// RL10: 30 anywhere resumes; repeatable suspend cycles
// RL11: Status read everywhere while busy
// RL12: Poll flag inverts programmed bit seven
// RL13: Poll flag zero erasing, one suspended
// RL14: Toggle flag inverts on each read
// RL15: Toggle flag stops once suspended
// RL16: Fail flag set; reset before anything else
// RL17: Programming cannot turn zero into one
// RL18: Erase timer flag shows erase started
// RL19: Alt toggle flips only in erasing blocks
// RL20: Alt toggle marks failed blocks after error
// RL21: Host ignores undefined status bits
// RL22: Block erase starts 50us after last select
// RL23: Suspend completes within 15us
// RL24: No command accepted during a program
// RL25: Mismatched write abandons partial sequence
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "fcsl_regs.svh"
module fcsl_host import fcsl_pkg::*; #(
  parameter int unsigned WP_CYC     = (`FCSL_T_WP_NS * `FCSL_CLK_KHZ + 999999) / 1000000,
  parameter int unsigned RD_CYC     = (`FCSL_T_RD_NS * `FCSL_CLK_KHZ + 999999) / 1000000,
  parameter int unsigned BLKWIN_CYC = (`FCSL_T_BLKWIN_US * `FCSL_CLK_KHZ) / 1000,
  parameter int unsigned SUSP_CYC   = (`FCSL_T_SUSP_US * `FCSL_CLK_KHZ + 999) / 1000
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [16:0] fl_addr,
  output logic      [7:0]  fl_dq_o,
  output logic             fl_dq_oe,
  input  wire logic [7:0]  fl_dq_i,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n
);
  localparam int unsigned SYNC_LAT = 4; // Pin-to-agreed-value latency
  localparam int unsigned RD_TOT   = RD_CYC + SYNC_LAT;

  // Reset image of the state record
  localparam fcsl_regs_t RST = '{st: FCSL_IDLE, op: FCSL_OP_NONE, addr: `FCSL_RST_ADDR,
                                 wdat: `FCSL_RST_WDATA, rdy: 1'b1, ce_n: 1'b1,
                                 oe_n: 1'b1, we_n: 1'b1, default: '0};

  if (WP_CYC < 1 || WP_CYC > 4095 || RD_TOT > 4095 || BLKWIN_CYC < 1 ||
      BLKWIN_CYC > 4095 || SUSP_CYC < 1 || SUSP_CYC > 4095) begin : g_chk
    $error("fcsl_host timing counts must lie in 1..4095");
  end

  fcsl_regs_t  q;       // Registered state
  fcsl_regs_t  n;       // Next state
  logic [7:0]  dq_stab; // Synchronised data pins
  logic        cmd_go;  // Command register written
  logic        ok;      // Command may be started
  fcsl_op_t    cop;     // Operation being written
  logic [25:0] sw;      // Current step: last, address, data
  logic [7:0]  cur;     // Byte just read
  logic [7:0]  mask;    // Defined status bits

  fcsl_sync #(
    .W (8)
  ) u_dq_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (fl_dq_i),
    .dout    (dq_stab)
  );

  // True for the operations that open with the unlock pair
  function automatic logic unl(input fcsl_op_t o);
    unl = (o == FCSL_OP_RESET_UNL) || (o == FCSL_OP_AUTOSEL) || (o == FCSL_OP_PROG) ||
          (o == FCSL_OP_BYP_ENTER) || (o == FCSL_OP_CHIP_ERA) || (o == FCSL_OP_BLK_ERA);
  endfunction

  // Write table: {last, address, data} for one step of one operation
  function automatic logic [25:0] seq(input fcsl_op_t o, input logic [2:0] s,
                                      input logic [16:0] ta, input logic [7:0] wv);
    logic [16:0] a5;
    logic [16:0] a2;
    a5  = {6'h00, `FCSL_CA_555}; // Upper bits driven low, device ignores them (see RL2)
    a2  = {6'h00, `FCSL_CA_2AA};
    seq = {1'b1, ta, `FCSL_CD_F0};
    if (unl(o) && s == 3'd0) begin
      seq = {1'b0, a5, `FCSL_CD_AA}; // see RL1
    end else if (unl(o) && s == 3'd1) begin
      seq = {1'b0, a2, `FCSL_CD_55}; // see RL1
    end else begin
      unique case (o)
        FCSL_OP_RESET_UNL: seq = {1'b1, ta, `FCSL_CD_F0}; // see RL3
        FCSL_OP_AUTOSEL:   seq = {1'b1, a5, `FCSL_CD_90}; // see RL4
        FCSL_OP_PROG:      seq = (s == 3'd2) ? {1'b0, a5, `FCSL_CD_A0} : {1'b1, ta, wv}; // see RL5
        FCSL_OP_BYP_ENTER: seq = {1'b1, a5, `FCSL_CD_20}; // see RL6
        FCSL_OP_BYP_PROG:  seq = (s == 3'd0) ? {1'b0, ta, `FCSL_CD_A0} : {1'b1, ta, wv}; // see RL6
        FCSL_OP_BYP_EXIT:  seq = (s == 3'd0) ? {1'b0, ta, `FCSL_CD_90} : {1'b1, ta, `FCSL_CD_00};
        FCSL_OP_CHIP_ERA, FCSL_OP_BLK_ERA: begin
          unique case (s)
            3'd2:    seq = {1'b0, a5, `FCSL_CD_80}; // see RL7
            3'd3:    seq = {1'b0, a5, `FCSL_CD_AA};
            3'd4:    seq = {1'b0, a2, `FCSL_CD_55};
            default: seq = (o == FCSL_OP_CHIP_ERA) ? {1'b1, a5, `FCSL_CD_10}
                                                   : {1'b1, ta, `FCSL_CD_30}; // see RL8
          endcase
        end
        FCSL_OP_BLK_ADD:   seq = {1'b1, ta, `FCSL_CD_30}; // see RL8
        FCSL_OP_SUSPEND:   seq = {1'b1, ta, `FCSL_CD_B0}; // see RL9
        FCSL_OP_RESUME:    seq = {1'b1, ta, `FCSL_CD_30}; // see RL10
        default:           seq = {1'b1, ta, `FCSL_CD_F0}; // see RL3
      endcase
    end
  endfunction

  // Acceptance check for a written operation code
  always_comb begin
    cop = fcsl_op_t'(hwdata[3:0]);
    ok  = (q.st == FCSL_IDLE); // Busy controller takes nothing (see RL24)
    if (hwdata[3:0] == 4'h0 || hwdata[3:0] == 4'hf) begin
      ok = 1'b0;
    end
    if (q.fail && cop != FCSL_OP_RESET && cop != FCSL_OP_RESET_UNL) begin
      ok = 1'b0; // Error must be cleared first (see RL16)
    end
    if (q.bypass && unl(cop)) begin
      ok = 1'b0; // Bypass refuses the commands that open with the unlock pair (see RL6)
    end
    if (!q.bypass && (cop == FCSL_OP_BYP_PROG || cop == FCSL_OP_BYP_EXIT)) begin
      ok = 1'b0;
    end
    if (cop == FCSL_OP_BLK_ADD && q.win == 12'h000) begin
      ok = 1'b0; // Erase already started, no more blocks (see RL22)
    end
    if ((cop == FCSL_OP_RESUME) != q.susp && (cop == FCSL_OP_RESUME || cop == FCSL_OP_SUSPEND)) begin
      ok = 1'b0; // Resume only when suspended, suspend only when not
    end
  end

  // Next-state logic: bus slave, write sequencer and status poller
  always_comb begin
    n      = q;
    cmd_go = 1'b0;
    sw     = seq(q.op, q.step, q.addr, q.wdat);
    cur    = dq_stab;
    mask   = (q.op == FCSL_OP_PROG || q.op == FCSL_OP_BYP_PROG) ? `FCSL_MASK_PROG
                                                                : `FCSL_MASK_ERASE;
    n.rdy  = 1'b1;
    n.aw   = 1'b0;
    // Address phase: capture, and load read data for the data phase
    if (hsel && hready && htrans[1]) begin
      n.aw     = hwrite;
      n.aoff   = haddr[7:0];
      n.amap   = (haddr[31:8] == 24'h000000);
      n.hrdata = 32'h00000000;
      if (!hwrite && haddr[31:8] == 24'h000000) begin
        unique case (haddr[7:0])
          `FCSL_OFF_CMD:    n.hrdata = {28'h0000000, q.op};
          `FCSL_OFF_ADDR:   n.hrdata = {15'h0000, q.addr};
          `FCSL_OFF_WDATA:  n.hrdata = {24'h000000, q.wdat};
          `FCSL_OFF_RDATA:  n.hrdata = {24'h000000, q.rdat};
          `FCSL_OFF_STATUS: begin
            n.hrdata[`FCSL_ST_BUSY]    = (q.st != FCSL_IDLE);
            n.hrdata[`FCSL_ST_DONE]    = q.done;
            n.hrdata[`FCSL_ST_FAIL]    = q.fail;
            n.hrdata[`FCSL_ST_BYPASS]  = q.bypass;
            n.hrdata[`FCSL_ST_SUSP]    = q.susp;
            n.hrdata[`FCSL_ST_WIN]     = (q.win != 12'h000);
            n.hrdata[`FCSL_ST_REFUSED] = q.refused;
            n.hrdata[`FCSL_ST_SBYTE +: 8] = q.sbyte;
          end
          default:          n.hrdata = 32'h00000000;
        endcase
      end
    end
    // Block-select window runs down
    if (q.win != 12'h000) begin
      n.win = q.win - 12'h001; // see RL22
    end
    // Data phase of a write
    if (q.aw && q.amap) begin
      unique case (q.aoff)
        `FCSL_OFF_ADDR:  n.addr = hwdata[16:0];
        `FCSL_OFF_WDATA: n.wdat = hwdata[7:0];
        `FCSL_OFF_CMD:   cmd_go = 1'b1;
        default:         n.addr = q.addr;
      endcase
    end
    // Start or refuse an operation
    if (cmd_go) begin
      if (!ok) begin
        n.refused = 1'b1;
      end else begin
        n.op      = cop;
        n.step    = 3'd0;
        n.done    = 1'b0;
        n.refused = 1'b0;
        n.havep   = 1'b0;
        n.chk     = 1'b0;
        n.cnt     = 12'(RD_TOT - 1);
        n.st      = (cop == FCSL_OP_READ || cop == FCSL_OP_POLL) ? FCSL_RPULSE : FCSL_WSET;
      end
    end
    unique case (q.st)
      FCSL_IDLE: begin
        n.foe = 1'b0;
      end
      // Address and data set up one cycle ahead of the strobe
      FCSL_WSET: begin
        n.fa   = sw[24:8];
        n.fdo  = sw[7:0];
        n.foe  = 1'b1;
        n.ce_n = 1'b0;
        n.cnt  = 12'(WP_CYC - 1);
        n.st   = FCSL_WPULSE;
      end
      // Write strobe low for WP_CYC cycles
      FCSL_WPULSE: begin
        n.we_n = 1'b0;
        if (q.cnt == 12'h000) begin
          n.st = FCSL_WHOLD;
        end else begin
          n.cnt = q.cnt - 12'h001;
        end
      end
      // Strobe rises, data still driven
      FCSL_WHOLD: begin
        n.we_n = 1'b1;
        n.st   = FCSL_WDONE;
      end
      // Release bus, then next step or finish
      FCSL_WDONE: begin
        n.foe  = 1'b0;
        n.ce_n = 1'b1;
        if (!sw[25]) begin
          n.step = q.step + 3'd1;
          n.st   = FCSL_WSET;
        end else begin
          n.st   = FCSL_IDLE;
          n.done = 1'b1;
          unique case (q.op)
            FCSL_OP_PROG, FCSL_OP_BYP_PROG, FCSL_OP_CHIP_ERA, FCSL_OP_RESUME: begin
              n.done = 1'b0;
              n.susp = (q.op == FCSL_OP_RESUME) ? 1'b0 : q.susp; // see RL10
              n.cnt  = 12'(RD_TOT - 1);
              n.st   = FCSL_RPULSE; // Read status until finished (see RL7)
            end
            FCSL_OP_SUSPEND: begin
              n.done = 1'b0;
              n.cnt  = 12'(SUSP_CYC - 1);
              n.st   = FCSL_WAIT; // see RL23
            end
            FCSL_OP_BLK_ERA, FCSL_OP_BLK_ADD: n.win = 12'(BLKWIN_CYC); // see RL22
            FCSL_OP_BYP_ENTER: n.bypass = 1'b1;
            FCSL_OP_BYP_EXIT:  n.bypass = 1'b0;
            FCSL_OP_RESET, FCSL_OP_RESET_UNL: n.fail = 1'b0; // see RL3
            default:           n.done = 1'b1;
          endcase
        end
      end
      // Output enable low, wait access time plus synchroniser
      FCSL_RPULSE: begin
        n.fa   = q.addr;
        n.foe  = 1'b0;
        n.ce_n = 1'b0;
        n.oe_n = 1'b0;
        if (q.cnt == 12'h000) begin
          n.st = FCSL_REVAL;
        end else begin
          n.cnt = q.cnt - 12'h001;
        end
      end
      // Take the byte and judge the toggle pattern
      FCSL_REVAL: begin
        n.oe_n = 1'b1;
        n.ce_n = 1'b1;
        n.rdat = cur;
        n.cnt  = 12'(RD_TOT - 1);
        n.st   = FCSL_RPULSE;
        if (q.op == FCSL_OP_READ) begin
          n.st   = FCSL_IDLE;
          n.done = 1'b1;
        end else begin
          n.sbyte = cur & mask; // Undefined positions cleared (see RL21)
          n.prev  = cur;
          n.havep = 1'b1;
          if (q.havep && q.prev[`FCSL_SB_TOGGLE] == cur[`FCSL_SB_TOGGLE]) begin
            n.st   = FCSL_IDLE; // Toggle stopped: finished (see RL14)
            n.done = 1'b1;
          end else if (q.havep && q.chk) begin
            n.st   = FCSL_IDLE; // Still toggling after error seen (see RL16)
            n.done = 1'b1;
            n.fail = 1'b1;
          end else if (q.havep && cur[`FCSL_SB_FAIL]) begin
            n.chk   = 1'b1; // Two fresh reads decide (see RL16)
            n.havep = 1'b0;
          end
        end
      end
      // Fixed wait for the erase to halt
      FCSL_WAIT: begin
        if (q.cnt == 12'h000) begin
          n.st   = FCSL_IDLE;
          n.done = 1'b1;
          n.susp = 1'b1; // see RL9
        end else begin
          n.cnt = q.cnt - 12'h001;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  assign hrdata    = q.hrdata;
  assign hreadyout = q.rdy;
  assign hresp     = 1'b0 & q.rdy;
  assign fl_addr   = q.fa;
  assign fl_dq_o   = q.fdo;
  assign fl_dq_oe  = q.foe;
  assign fl_ce_n   = q.ce_n;
  assign fl_oe_n   = q.oe_n;
  assign fl_we_n   = q.we_n;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_strobe(int s);
    $fell(fl_we_n) && unl(q.op) && q.step == s;
  endsequence
  sequence s_last(fcsl_op_t o);
    q.st == FCSL_WDONE && q.op == o && sw[25];
  endsequence

  property p_unlock_aa;
    s_strobe(0) |-> fl_addr[10:0] == `FCSL_CA_555 && fl_dq_o == `FCSL_CD_AA;
  endproperty
  a_unlock_aa: assert property (p_unlock_aa) else $error("first unlock write wrong"); // see RL1
  property p_unlock_55;
    s_strobe(1) |-> fl_addr[10:0] == `FCSL_CA_2AA && fl_dq_o == `FCSL_CD_55;
  endproperty
  a_unlock_55: assert property (p_unlock_55) else $error("second unlock write wrong"); // see RL1
  property p_prog_data;
    $fell(fl_we_n) && q.op == FCSL_OP_PROG && q.step == 3'd3 |->
      fl_dq_o == q.wdat && fl_addr == q.addr && fl_dq_oe;
  endproperty
  a_prog_data: assert property (p_prog_data) else $error("program data write wrong"); // see RL5
  property p_reset_clears;
    s_last(FCSL_OP_RESET) or s_last(FCSL_OP_RESET_UNL) |=> !q.fail && q.done;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left error"); // see RL3
  property p_bypass_exit;
    s_last(FCSL_OP_BYP_EXIT) |=> !q.bypass ##1 !q.bypass;
  endproperty
  a_bypass_exit: assert property (p_bypass_exit) else $error("bypass not left"); // see RL6
  property p_erase_polls;
    s_last(FCSL_OP_CHIP_ERA) |=> q.st == FCSL_RPULSE ##1 !fl_oe_n[*2];
  endproperty
  a_erase_polls: assert property (p_erase_polls) else $error("no poll after erase"); // see RL7
  property p_blk_window;
    q.st == FCSL_WSET && q.op == FCSL_OP_BLK_ADD && $past(q.st) == FCSL_IDLE |->
      $past(q.win) != 12'h000;
  endproperty
  a_blk_window: assert property (p_blk_window) else $error("block added too late"); // see RL8
  property p_fail_locks;
    q.fail && $fell(fl_we_n) |-> q.op == FCSL_OP_RESET || q.op == FCSL_OP_RESET_UNL;
  endproperty
  a_fail_locks: assert property (p_fail_locks) else $error("command during error"); // see RL16
  property p_mask;
    (q.sbyte & ~`FCSL_MASK_ERASE) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("undefined status bit kept"); // see RL21
  property p_susp_wait;
    s_last(FCSL_OP_SUSPEND) |=> (!q.done && !q.susp)[*8];
  endproperty
  a_susp_wait: assert property (p_susp_wait) else $error("suspend ended early"); // see RL9
  property p_resume;
    s_last(FCSL_OP_RESUME) |=> !q.susp && q.st == FCSL_RPULSE;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not polled"); // see RL10
endmodule

// ### fcsl_flash_model.sv
// Behavioural byte-wide flash answering the sequencer's pin cycles
`timescale 1ns/1ps
`include "fcsl_regs.svh"
module fcsl_flash_model #(
  parameter int BUSY_RD = 6  // Status reads before a job ends
) (
  input  wire logic [16:0] fl_addr,
  input  wire logic [7:0]  fl_dq_o,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_we_n,
  input  wire logic        fail_next,
  output logic      [7:0]  fl_dq_i
);
  logic [7:0] mem [0:131071];  // Array image
  logic [7:0] q;               // Last byte read out
  logic [7:0] pv;              // Value being programmed
  logic       byp, er, fl, tg; // Bypass, erasing, failed, toggle
  int         ph, busy;        // Sequence step, busy reads left
  wire [10:0] ca = fl_addr[10:0];      // Decoded part
  wire        u = ca == `FCSL_CA_555;  // Command address hit
  wire [7:0]  d = fl_dq_o;             // Write data
  // Released bus shows the inverse so a stale byte never passes
  assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? q : ~q;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    q = 8'h00;
    pv = 8'h00;
    {byp, er, fl, tg} = 4'h0;
    ph = 0;
    busy = 0;
  end
  // Command decoder on the write strobe's rising edge
  always @(posedge fl_we_n) begin
    if (!fl_ce_n && busy == 0) begin  // Deaf while busy
      if (d == `FCSL_CD_F0 && ph != 4) begin
        ph = 0;
        fl = 1'b0;
      end else if (fl) ph = 0;  // Only reset clears it
      else case (ph)
        0: if (byp) ph = d == `FCSL_CD_A0 ? 4 : d == `FCSL_CD_90 ? 9 : 0;
           else ph = (u && d == `FCSL_CD_AA) ? 1 : 0;
        1, 6: ph = (ca == `FCSL_CA_2AA && d == `FCSL_CD_55) ? ph + 1 : 0;
        2: begin  // Third write of an unlocked command
          byp = byp | (u && d == `FCSL_CD_20);
          ph = !u ? 0 : d == `FCSL_CD_A0 ? 4 : d == `FCSL_CD_80 ? 5 : 0;
        end
        4: begin  // Latch location and value
          pv = d;
          mem[fl_addr] = mem[fl_addr] & d;  // Never 0 to 1
          er = 1'b0;
          fl = fail_next;
          busy = fail_next ? 0 : BUSY_RD;  // A failed job is over
          ph = 0;
        end
        5: ph = (u && d == `FCSL_CD_AA) ? 6 : 0;
        7: begin  // Whole-array erase
          if (u && d == `FCSL_CD_10) begin
            foreach (mem[i]) mem[i] = 8'hff;
            er = 1'b1;
            fl = fail_next;
            busy = fail_next ? 0 : BUSY_RD;
          end
          ph = 0;
        end
        9: begin  // Bypass exit second write
          byp = d != `FCSL_CD_00;
          ph = 0;
        end
        default: ph = 0;
      endcase
    end
  end
  // Strobes fall together, so settle before looking
  always @(negedge fl_oe_n or negedge fl_ce_n) begin
    #1;
    if (!fl_ce_n && !fl_oe_n) begin
      if (busy > 0 || fl) begin  // Any address
        tg = ~tg;
        if (er) q = {1'b0, tg, fl, 2'b01, tg, 2'b00};
        else q = {~pv[7], tg, fl, 5'h00};
        if (busy > 0) busy = busy - 1;
      end else q = mem[fl_addr];
    end
  end
endmodule

// ### fcsl_host_tb.sv
// Self-checking bench of the flash sequencer against a behavioural flash
`timescale 1ns/1ps
`include "fcsl_regs.svh"
module fcsl_host_tb;
  logic        hclk, hresetn;  // Bus clock, active-low reset
  logic        hsel, hwrite, fail_next;
  logic [31:0] haddr, hwdata, rd, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  logic [16:0] fl_addr;
  logic [7:0]  fl_dq_o, fl_dq_i;
  int          miscompares, checked;
  wire         hready = hreadyout;  // Single slave drives ready
  fcsl_host #(.SUSP_CYC(20), .BLKWIN_CYC(50)) i_fcsl_host (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
  fcsl_flash_model i_fcsl_flash_model (
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fail_next(fail_next), .fl_dq_i(fl_dq_i));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // One single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);  // Slave answers OKAY only
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Issue an opcode and poll until no longer busy
  task automatic cmd(input logic [3:0] op);
    ahb(1'b1, `FCSL_OFF_CMD, {28'h0, op});
    do ahb(1'b0, `FCSL_OFF_STATUS, 32'h0); while (rd[`FCSL_ST_BUSY] !== 1'b0);
  endtask
  task automatic prog(input logic [16:0] a, input logic [7:0] v, input logic [3:0] op,
                      input logic f);
    ahb(1'b1, `FCSL_OFF_ADDR, {15'h0, a});
    ahb(1'b1, `FCSL_OFF_WDATA, {24'h0, v});
    cmd(op);
    chk(32'(rd[`FCSL_ST_FAIL -: 2]), {30'h0, f, 1'b1});
  endtask
  task automatic rdb(input logic [16:0] a, input logic [7:0] v);
    ahb(1'b1, `FCSL_OFF_ADDR, {15'h0, a});
    cmd(4'hc);
    ahb(1'b0, `FCSL_OFF_RDATA, 32'h0);
    chk(rd, {24'h0, v});
  endtask
  task automatic t_regs;  // Reset images and an unmapped word
    ahb(1'b0, `FCSL_OFF_ADDR, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, `FCSL_OFF_WDATA, 32'h0);
    chk(rd, 32'hff);
    ahb(1'b1, 8'h40, 32'h1234);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_prog;  // Program one place twice, high address bits set
    prog(17'h1a345, 8'h0f, 4'h3, 1'b0);
    rdb(17'h1a345, 8'h0f);
    prog(17'h1a345, 8'hf0, 4'h3, 1'b0);
    rdb(17'h1a345, 8'h00);
  endtask
  task automatic t_erase;  // Whole-array erase restores ones
    cmd(4'h7);
    chk(32'(rd[`FCSL_ST_FAIL -: 2]), 32'h1);
    rdb(17'h1a345, 8'hff);
  endtask
  task automatic t_byp;  // Bypass program, refusals in and after bypass
    cmd(4'h4);
    chk(32'(rd[`FCSL_ST_BYPASS]), 32'h1);
    prog(17'h00155, 8'h5a, 4'h5, 1'b0);
    rdb(17'h00155, 8'h5a);
    cmd(4'h3);
    chk(32'(rd[`FCSL_ST_REFUSED]), 32'h1);
    cmd(4'h6);
    chk(32'(rd[`FCSL_ST_BYPASS]), 32'h0);
    cmd(4'h5);
    chk(32'(rd[`FCSL_ST_REFUSED]), 32'h1);
  endtask
  task automatic t_fail;  // A failed program blocks commands until reset
    fail_next <= 1'b1;
    prog(17'h00200, 8'h33, 4'h3, 1'b1);
    fail_next <= 1'b0;
    cmd(4'h3);
    chk(32'(rd[`FCSL_ST_REFUSED]), 32'h1);
    cmd(4'he);
    chk(32'(rd[`FCSL_ST_FAIL]), 32'h0);
    rdb(17'h00200, 8'h33);
  endtask
  task automatic t_ref;  // Illegal and out-of-place opcodes
    logic [3:0] ops [4] = '{4'h0, 4'hf, 4'h9, 4'hb};
    foreach (ops[i]) begin
      cmd(ops[i]);
      chk(32'(rd[`FCSL_ST_REFUSED]), 32'h1);
    end
    cmd(4'h1);
    chk(32'(rd[`FCSL_ST_REFUSED]), 32'h0);
  endtask
  task automatic t_blk;  // Identify, block erase, add, suspend, resume, poll
    cmd(4'h2);
    ahb(1'b0, `FCSL_OFF_CMD, 32'h0);
    chk(rd, 32'h2);
    cmd(4'h8);
    chk(32'(rd[`FCSL_ST_WIN]), 32'h1);
    cmd(4'h9);
    chk(32'(rd[`FCSL_ST_REFUSED]), 32'h0);
    cmd(4'ha);
    chk(32'(rd[`FCSL_ST_SUSP]), 32'h1);
    cmd(4'hb);
    cmd(4'hd);
    chk(32'(rd[`FCSL_ST_SUSP:`FCSL_ST_DONE]), 32'h1);
  endtask
  task automatic finish_test;
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    fail_next = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_prog;
    t_erase;
    t_byp;
    t_fail;
    t_ref;
    t_blk;
    finish_test;
  end
  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    finish_test;
  end
endmodule
